// [hw/pcc_map.vh]
// pcc_map.vh: register offsets, fields, reset values and timing counts for the
// pll clock configuration block; assumes a 16-bit register word, 16-bit address
`ifndef PCC_MAP_VH
`define PCC_MAP_VH

`define PCC_ADDR_W          16
`define PCC_DATA_W          16
`define PCC_FBMUL_ADDR      16'hf000
`define PCC_PRESC_ADDR      16'hf001
`define PCC_SRC_ADDR        16'hf002
`define PCC_ENABLE_ADDR     16'hf003
`define PCC_LOCK_ADDR       16'hf004
`define PCC_CLKOUT_ADDR     16'hf005
`define PCC_FBMUL_RST       16'h0060
`define PCC_PRESC_RST       16'h0000
`define PCC_SRC_RST         16'h0000
`define PCC_CLKOUT_RST      16'h0000
`define PCC_FBMUL_MSB       6
`define PCC_PRESC_MSB       1
`define PCC_CLKOUT_MSB      2
`define PCC_SRC_BIT         0
`define PCC_ENABLE_BIT      0
`define PCC_LOCK_BIT        0
`define PCC_PRESC_DIV1      2'h0
`define PCC_PRESC_DIV2      2'h1
`define PCC_PRESC_DIV4      2'h2
`define PCC_PRESC_DIV8      2'h3
`define PCC_LOCK_TIME_NS    1000
`define PCC_CLK_PERIOD_NS   10
`define PCC_LOCK_CYCLES     ((`PCC_LOCK_TIME_NS + `PCC_CLK_PERIOD_NS - 1) / `PCC_CLK_PERIOD_NS)
`define PCC_FBMUL_MIN       7'h01

`endif

// [hw/pcc_prescaler.v]
// pcc_prescaler.v: divides the master clock by 1, 2, 4 or 8 as a one-cycle enable
// assumes the master clock pin is sampled synchronously on mclk_in
`timescale 1ns/1ps
`include "pcc_map.vh"

module pcc_prescaler
(
    input  wire       mclk_in,
    input  wire       rst_n_in,
    input  wire       run_in,
    input  wire [1:0] div_sel_in,
    output wire       tick_out
);
    reg  [2:0] count_r;
    wire [2:0] last;

    function [2:0] pcc_div_last;
        input [1:0] code;
        begin
            case (code)
                `PCC_PRESC_DIV1: pcc_div_last = 3'h0;
                `PCC_PRESC_DIV2: pcc_div_last = 3'h1;
                `PCC_PRESC_DIV4: pcc_div_last = 3'h3;
                default:         pcc_div_last = 3'h7;
            endcase
        end
    endfunction

    assign last     = pcc_div_last(div_sel_in);
    // count holds between pin edges; >= recovers if the code shrinks mid count
    assign tick_out = run_in && (count_r >= last);

    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            count_r <= 3'h0;
        else if (run_in)
            count_r <= (count_r >= last) ? 3'h0 : count_r + 3'h1;
    end
endmodule // pcc_prescaler

// [hw/pcc_clock_config.v]
// pcc_clock_config.v: pll configuration registers, enable-edge activation,
// prescaler, multiplier model, source select and lock flag.
// assumes a simple synchronous register port: one-cycle write/read strobes.
// Functional notes
// R1 - feedback multiplier is bits [6:0], resets to 96.
// R2 - multiplier code is an unsigned integer equal to the factor.
// R3 - pll rate is prescaled input times multiplier; it clocks the core.
// R4 - written settings act only when enable bit goes from 0 to 1.
// R5 - prescale code 00/01/10/11 divides master clock by 1/2/4/8; resets 00.
// R6 - software picks the prescale bringing the pll input near nominal.
// R7 - source bit 0 picks master pin, 1 picks pll output; resets 0.
// R8 - default setup gives nominal pll output rate.
// R9 - software should nearly always pick the pll output.
// R10 - enable low: no pll output, no lock attempt.
// R11 - enable rising also loads the clock output control register.
// R12 - lock flag reads 1 only when enabled, configured, fed and settled.
// R13 - configuration registers read back the last written value.
// R14 - reserved upper bits reset to zero and do nothing.
`timescale 1ns/1ps
`include "pcc_map.vh"

module pcc_clock_config
(
    input  wire                   mclk_in,
    input  wire                   rst_n_in,
    input  wire                   master_clock_pin_in,
    input  wire                   pll_ref_stable_in,
    input  wire [`PCC_ADDR_W-1:0] reg_addr_in,
    input  wire [`PCC_DATA_W-1:0] reg_wdata_in,
    input  wire                   reg_wr_in,
    input  wire                   reg_rd_in,
    output reg  [`PCC_DATA_W-1:0] reg_rdata_out,
    output reg                    reg_rvalid_out,
    output reg  [6:0]             active_multiplier_out,
    output reg  [1:0]             active_prescale_out,
    output reg                    active_source_out,
    output reg  [2:0]             active_clkout_out,
    output wire                   pll_ref_tick_out,
    output wire                   pll_running_out,
    output wire                   sys_clk_tick_out,
    output wire                   pll_locked_out
);
    localparam [1:0] ST_OFF    = 2'h0;
    localparam [1:0] ST_SETTLE = 2'h1;
    localparam [1:0] ST_LOCKED = 2'h2;
    localparam integer LOCK_CYCLES = `PCC_LOCK_CYCLES;
    localparam [15:0]  LOCK_CNT    = LOCK_CYCLES[15:0];
    localparam [15:0]  FBMUL_RST   = `PCC_FBMUL_RST;

    reg  [`PCC_DATA_W-1:0] feedback_multiplier_r;
    reg  [`PCC_DATA_W-1:0] input_prescaler_r;
    reg  [`PCC_DATA_W-1:0] source_select_r;
    reg  [`PCC_DATA_W-1:0] clkout_ctrl_r;
    reg                    pll_enable_r;
    reg  [1:0]             state_r;
    reg  [1:0]             state_nxt;
    reg  [15:0]            settle_r;
    reg  [6:0]             fb_count_r;
    reg                    pin_q_r;
    wire                   enable_rise;
    wire                   wr_enable;
    wire                   ref_tick;
    wire                   pin_edge;
    wire                   config_ok;

    function sel;
        input [`PCC_ADDR_W-1:0] a;
        input [`PCC_ADDR_W-1:0] b;
        begin
            sel = (a == b);
        end
    endfunction

    assign wr_enable   = reg_wr_in && sel(reg_addr_in, `PCC_ENABLE_ADDR);
    assign enable_rise = wr_enable && !pll_enable_r && reg_wdata_in[`PCC_ENABLE_BIT]; // [R4] [R11]

    // register writes; config registers store all bits so reads return the written word, enable stores only bit 0
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            feedback_multiplier_r <= `PCC_FBMUL_RST; // [R1] [R14]
            input_prescaler_r     <= `PCC_PRESC_RST; // [R5]
            source_select_r       <= `PCC_SRC_RST;   // [R7]
            clkout_ctrl_r         <= `PCC_CLKOUT_RST;
            pll_enable_r          <= 1'b0;
        end
        else if (reg_wr_in)
        begin
            if (sel(reg_addr_in, `PCC_FBMUL_ADDR))
                feedback_multiplier_r <= reg_wdata_in; // [R13]
            if (sel(reg_addr_in, `PCC_PRESC_ADDR))
                input_prescaler_r <= reg_wdata_in;
            if (sel(reg_addr_in, `PCC_SRC_ADDR))
                source_select_r <= reg_wdata_in;
            if (sel(reg_addr_in, `PCC_CLKOUT_ADDR))
                clkout_ctrl_r <= reg_wdata_in;
            if (wr_enable)
                pll_enable_r <= reg_wdata_in[`PCC_ENABLE_BIT];
        end
    end

    // active settings copy only the documented field bits on enable rise
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            active_multiplier_out <= FBMUL_RST[`PCC_FBMUL_MSB:0];
            active_prescale_out   <= `PCC_PRESC_DIV1;
            active_source_out     <= 1'b0;
            active_clkout_out     <= 3'h0;
        end
        else if (enable_rise)
        begin
            active_multiplier_out <= feedback_multiplier_r[`PCC_FBMUL_MSB:0]; // [R2] [R4] [R14]
            active_prescale_out   <= input_prescaler_r[`PCC_PRESC_MSB:0];     // [R4] [R5]
            active_source_out     <= source_select_r[`PCC_SRC_BIT];           // [R4] [R7]
            active_clkout_out     <= clkout_ctrl_r[`PCC_CLKOUT_MSB:0];        // [R11]
        end
    end

    // master pin rising edge, then prescaled reference tick
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            pin_q_r <= 1'b0;
        else
            pin_q_r <= master_clock_pin_in;
    end
    assign pin_edge = master_clock_pin_in && !pin_q_r;

    pcc_prescaler u_prescaler
    (
        .mclk_in    (mclk_in),
        .rst_n_in   (rst_n_in),
        .run_in     (pin_edge && pll_enable_r),
        .div_sel_in (active_prescale_out),
        .tick_out   (ref_tick)
    ); // [R5]
    assign pll_ref_tick_out = ref_tick;

    assign config_ok = (active_multiplier_out >= `PCC_FBMUL_MIN);

    // lock sequencer: no attempt while disabled
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF:
                if (pll_enable_r && config_ok && pll_ref_stable_in)
                    state_nxt = ST_SETTLE; // [R10]
            ST_SETTLE:
                if (!pll_enable_r || !pll_ref_stable_in)
                    state_nxt = ST_OFF;
                else if (settle_r == LOCK_CNT - 16'h0001)
                    state_nxt = ST_LOCKED;
            ST_LOCKED:
                if (!pll_enable_r || !pll_ref_stable_in || !config_ok)
                    state_nxt = ST_OFF;
            default:
                state_nxt = ST_OFF;
        endcase
    end

    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_r  <= ST_OFF;
            settle_r <= 16'h0000;
        end
        else
        begin
            state_r  <= (enable_rise) ? ST_OFF : state_nxt;
            settle_r <= (state_r == ST_SETTLE) ? settle_r + 16'h0001 : 16'h0000;
        end
    end

    // gated by the enable bit so lock and pll ticks drop in the cycle of disable
    assign pll_locked_out  = (state_r == ST_LOCKED) && pll_enable_r; // [R12] [R10]
    assign pll_running_out = pll_enable_r;                     // [R10]

    // multiplier model: each reference tick loads the active factor, which then counts down to zero
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            fb_count_r <= 7'h00;
        else if (!pll_enable_r)
            fb_count_r <= 7'h00;
        else if (ref_tick)
            fb_count_r <= active_multiplier_out; // [R3] [R8]
        else if (fb_count_r != 7'h00)
            fb_count_r <= fb_count_r - 7'h01;
    end

    // system clock tick: pin edge, or pll output gated when pll is off
    assign sys_clk_tick_out = active_source_out
                            ? (pll_locked_out && fb_count_r != 7'h00) // [R7] [R10]
                            : pin_edge;

    // register reads, one cycle latency
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            reg_rdata_out  <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in)
            begin
                case (reg_addr_in)
                    `PCC_FBMUL_ADDR:  reg_rdata_out <= feedback_multiplier_r; // [R13]
                    `PCC_PRESC_ADDR:  reg_rdata_out <= input_prescaler_r;
                    `PCC_SRC_ADDR:    reg_rdata_out <= source_select_r;
                    `PCC_ENABLE_ADDR: reg_rdata_out <= {15'h0000, pll_enable_r};
                    `PCC_LOCK_ADDR:   reg_rdata_out <= {15'h0000, pll_locked_out}; // [R12]
                    `PCC_CLKOUT_ADDR: reg_rdata_out <= clkout_ctrl_r;
                    default:          reg_rdata_out <= 16'h0000;
                endcase
            end
        end
    end
endmodule // pcc_clock_config

// [testbench/pcc_props.sv]
// pcc_props.sv: port checker for pcc_clock_config
// assumes it is bound to the design from the bench top file
`timescale 1ns/1ps
module pcc_props
(
    input wire logic        mclk_in,
    input wire logic        rst_n_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        reg_rvalid_out,
    input wire logic [6:0]  active_multiplier_out,
    input wire logic [1:0]  active_prescale_out,
    input wire logic        active_source_out,
    input wire logic        pll_ref_tick_out,
    input wire logic        pll_running_out,
    input wire logic        sys_clk_tick_out,
    input wire logic        pll_locked_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    wire en_wr = reg_wr_in && reg_addr_in == 16'hf003;

    a_rd_answered: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    a_rvalid_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
        else $error("answer without read");
    a_config_hold: assert property (($changed(active_multiplier_out)
        || $changed(active_prescale_out) || $changed(active_source_out))
        |-> $past(en_wr && reg_wdata_in[0] && !pll_running_out))
        else $error("active setting moved without enable rise");
    a_lock_needs_run: assert property (pll_locked_out |-> pll_running_out)
        else $error("locked while disabled");
    a_idle_no_tick: assert property (!pll_running_out |-> !pll_ref_tick_out
        && !(active_source_out && sys_clk_tick_out)) else $error("tick while disabled");
    a_lock_settles: assert property ($rose(pll_running_out) |-> !pll_locked_out [*8])
        else $error("lock without settling");
    a_pll_tick_lock: assert property (active_source_out && sys_clk_tick_out
        |-> pll_locked_out) else $error("pll clock before lock");
    a_ref_drives_sys: assert property (pll_ref_tick_out && pll_locked_out
        && active_source_out |=> sys_clk_tick_out || !pll_locked_out)
        else $error("no pll output after reference tick");
    a_enable_store: assert property (en_wr |=> pll_running_out == $past(reg_wdata_in[0]))
        else $error("enable bit not stored");
    a_lock_readback: assert property (reg_rd_in && reg_addr_in == 16'hf004
        |=> reg_rdata_out == {15'h0, $past(pll_locked_out)}) else $error("lock read wrong");
endmodule // pcc_props

// [testbench/pcc_mclk_src.sv]
// pcc_mclk_src.sv: master clock source feeding the master clock pin
// assumes the bench starts and stops it through run_in
`timescale 1ns/1ps
module pcc_mclk_src
#(
    parameter int HALF_NS = 40
)
(
    input  wire logic run_in,
    output logic      pin_out,
    output logic      stable_out
);
    int edges = 0;
    initial pin_out = 1'b0;
    // pin stands low while stopped; stable only after a few cycles
    always #(HALF_NS) pin_out = run_in ? ~pin_out : 1'b0;
    always @(posedge pin_out or negedge run_in) edges = run_in ? edges + 1 : 0;
    assign stable_out = run_in && edges >= 4;
endmodule // pcc_mclk_src

// [testbench/testbench.sv]
// testbench.sv: self-checking bench for pcc_clock_config
// assumes pcc_props and pcc_mclk_src are compiled before it
`timescale 1ns/1ps
module testbench;
    typedef struct {logic wr; logic [15:0] a; logic [15:0] d; logic [15:0] e;} pcc_row_t;
    logic        mclk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        run = 1'b0;
    logic        pin, stable;
    logic        pin_d = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] v;
    wire  [15:0] rdata;
    wire         rvalid, ref_tick, running, sys_tick, locked, src;
    wire  [6:0]  mul;
    wire  [1:0]  pre;
    wire  [2:0]  cko;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          n_pin = 0;
    int          n_ref = 0;
    int          n_sys = 0;
    int          i;
    pcc_row_t    rows[9] = '{
        '{1'b0, 16'hf000, 16'h0000, 16'h0060},
        '{1'b0, 16'hf001, 16'h0000, 16'h0000},
        '{1'b0, 16'hf002, 16'h0000, 16'h0000},
        '{1'b1, 16'hf000, 16'hffd0, 16'hffd0},
        '{1'b1, 16'hf001, 16'hfffe, 16'hfffe},
        '{1'b1, 16'hf002, 16'hfff1, 16'hfff1},
        '{1'b1, 16'hf005, 16'h0003, 16'h0003},
        '{1'b1, 16'hf004, 16'h0001, 16'h0000},
        '{1'b1, 16'hf010, 16'h1234, 16'h0000}};

    pcc_mclk_src u_pcc_mclk_src (.run_in(run), .pin_out(pin), .stable_out(stable));
    pcc_clock_config u_pcc_clock_config (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .master_clock_pin_in(pin), .pll_ref_stable_in(stable), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .active_multiplier_out(mul), .active_prescale_out(pre),
        .active_source_out(src), .active_clkout_out(cko), .pll_ref_tick_out(ref_tick),
        .pll_running_out(running), .sys_clk_tick_out(sys_tick), .pll_locked_out(locked));

    always #5 mclk_in = ~mclk_in;
    always @(posedge mclk_in)
    begin
        pin_d <= pin;
        n_pin += (pin && !pin_d);
        n_ref += ref_tick;
        n_sys += sys_tick;
        cyc++;
        if (cyc == 8000)
        begin
            n_errors++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1;
        chk({15'h0, rvalid}, 16'h0001);
        d = rdata;
    endtask
    task automatic summarize();
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        run <= 1'b1;
        foreach (rows[k])
        begin
            if (rows[k].wr)
                wreg(rows[k].a, rows[k].d);
            rreg(rows[k].a, v);
            chk(v, rows[k].e);
        end
        chk({3'h0, cko, src, pre, mul}, 16'h0060);
        $display("register table done");
        wreg(16'hf003, 16'h0001);
        #1;
        chk({3'h0, cko, src, pre, mul}, {3'h0, 3'h3, 1'b1, 2'h2, 7'h50});
        i = 0;
        while (!locked && i < 400)
        begin
            @(posedge mclk_in);
            #1;
            i++;
        end
        chk({15'h0, locked && i >= 99}, 16'h0001);
        rreg(16'hf004, v);
        chk(v, 16'h0001);
        $display("enable and lock done");
        for (i = 0; i < 4; i++)
        begin
            wreg(16'hf003, 16'h0000);
            wreg(16'hf001, 16'(i));
            wreg(16'hf003, 16'h0001);
            n_pin = 0;
            n_ref = 0;
            n_sys = 0;
            repeat (640) @(posedge mclk_in);
            #1;
            chk({15'h0, (n_ref << i) + (1 << i) >= n_pin && (n_ref << i) <= n_pin + (1 << i)},
                16'h0001);
            chk({15'h0, n_sys > 0}, 16'h0001);
        end
        $display("prescale codes done");
        wreg(16'hf000, 16'h0020);
        wreg(16'hf003, 16'h0001);
        #1;
        chk({9'h0, mul}, 16'h0050);
        wreg(16'hf003, 16'h0000);
        repeat (2) @(posedge mclk_in);
        n_ref = 0;
        repeat (100) @(posedge mclk_in);
        #1;
        chk({14'h0, locked, n_ref != 0}, 16'h0000);
        wreg(16'hf003, 16'h0001);
        #1;
        chk({9'h0, mul}, 16'h0020);
        $display("disable and reload done");
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        #1;
        chk({2'h0, locked, cko, src, pre, mul}, 16'h0060);
        @(posedge mclk_in);
        rst_n_in <= 1'b1;
        rreg(16'hf002, v);
        chk(v, 16'h0000);
        $display("mid-run reset done");
        summarize();
    end
endmodule // testbench

bind pcc_clock_config pcc_props u_pcc_props (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .active_multiplier_out(active_multiplier_out), .active_prescale_out(active_prescale_out),
    .active_source_out(active_source_out), .pll_ref_tick_out(pll_ref_tick_out),
    .pll_running_out(pll_running_out), .sys_clk_tick_out(sys_clk_tick_out),
    .pll_locked_out(pll_locked_out));
